//--- hdl/gcs_gpio_config.sv
// Functional notes
// - pin 0 source: output bit or detect 0
// - pin 1 source: por, bit, detect, lock
// - pin 2 source: bit or one of three clocks
// - other source codes reserved, no behaviour
// - pull field: none, down, up; reset down
// - bit 1 enables input buffer, resets off
// - bit 0 enables output driver, resets on
// - reset register bit 0 restores power-up state
// - registers reached over management bus, chip select
// - register source drives output data bit
`timescale 1ns/1ps
`default_nettype none
module gcs_gpio_config #(
   parameter int PINS = 3
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // management bus pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        bus_select,
   // internal sources
   input  wire logic [1:0]  signal_detect,
   input  wire logic        cdr_locked,
   input  wire logic        por_status,
   input  wire logic        always_on_clk,
   input  wire logic        lvds_tx_clk,
   input  wire logic        recovered_clk,
   // general pins
   input  wire logic [2:0]  gpio_in,
   output logic      [2:0]  gpio_out,
   output logic      [2:0]  gpio_oe,
   output logic      [2:0]  input_buffer_on,
   output logic      [2:0]  pull_up_on,
   output logic      [2:0]  pull_down_on
);

   // ****************************************
   // parameter check
   // ****************************************
   if (PINS != 3) begin : g_pins_check
      $error("only three general pins are supported");
   end

   // ****************************************
   // bus engine
   // ****************************************
   gcs_reg_if regs ();

   gcs_serial_slave u_bus (
      .ref_clk    (ref_clk),
      .arst_n     (arst_n),
      .scl_in     (scl_in),
      .sda_in     (sda_in),
      .sda_out    (sda_out),
      .sda_oe     (sda_oe),
      .bus_select (bus_select),
      .regs       (regs.engine)
   );

   // ****************************************
   // source selection
   // ****************************************
   function automatic logic pin_source(
      input logic [1:0] pin,
      input logic [3:0] mode,
      input logic [2:0] gpo,
      input logic [1:0] sd,
      input logic       lock,
      input logic       por,
      input logic [2:0] clks
   );
      logic v;
      v = 1'b0;
      case (pin)
         2'h0: begin
            case (mode)
               gcs_pkg::SRC0_GPO: v = gpo[0];
               gcs_pkg::SRC0_SD0: v = sd[0];
               default:           v = 1'b0;
            endcase
         end
         2'h1: begin
            case (mode)
               gcs_pkg::SRC1_POR:  v = por;
               gcs_pkg::SRC1_GPO:  v = gpo[1];
               gcs_pkg::SRC1_SD1:  v = sd[1];
               gcs_pkg::SRC1_LOCK: v = lock;
               default:            v = 1'b0;
            endcase
         end
         2'h2: begin
            case (mode)
               gcs_pkg::SRC2_GPO:     v = gpo[2];
               gcs_pkg::SRC2_AON_CLK: v = clks[0];
               gcs_pkg::SRC2_TX_CLK:  v = clks[1];
               gcs_pkg::SRC2_REC_CLK: v = clks[2];
               default:               v = 1'b0;
            endcase
         end
         default: v = 1'b0;
      endcase
      return v;
   endfunction : pin_source

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] pin_cfg [PINS];
   logic [2:0] general_output_value;
   logic       soft_reset_request;
   logic [7:0] read_value;
   wire        wr_reset;
   wire        wr_gp_out;
   wire  [2:0] wr_cfg;
   wire  [2:0] clks;
   wire  [2:0] gp_in_seen;

   assign wr_reset  = regs.wr_en && (regs.addr == gcs_pkg::OFF_RESET);
   assign wr_gp_out = regs.wr_en && (regs.addr == gcs_pkg::OFF_GP_OUT);
   assign wr_cfg[0] = regs.wr_en && (regs.addr == gcs_pkg::OFF_PIN_CFG0);
   assign wr_cfg[1] = regs.wr_en && (regs.addr == gcs_pkg::OFF_PIN_CFG1);
   assign wr_cfg[2] = regs.wr_en && (regs.addr == gcs_pkg::OFF_PIN_CFG2);
   assign clks      = {recovered_clk, lvds_tx_clk, always_on_clk};

   // request lasts one cycle, then reads back zero
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         soft_reset_request <= 1'b0;
      end else begin
         soft_reset_request <=
            wr_reset & regs.wdata[gcs_pkg::SOFT_RST_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < PINS; i++) begin
            pin_cfg[i] <= gcs_pkg::CFG_RESET;
         end
      end else begin
         for (int i = 0; i < PINS; i++) begin
            if (soft_reset_request) begin
               pin_cfg[i] <= gcs_pkg::CFG_RESET;
            end else if (wr_cfg[i]) begin
               pin_cfg[i] <= regs.wdata;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         general_output_value <= gcs_pkg::GP_OUT_RESET;
      end else if (soft_reset_request) begin
         general_output_value <= gcs_pkg::GP_OUT_RESET;
      end else if (wr_gp_out) begin
         general_output_value <= regs.wdata[2:0];
      end
   end

   // ****************************************
   // pin controls
   // ****************************************
   for (genvar p = 0; p < 3; p++) begin : g_pin
      assign gpio_out[p] = pin_source(2'(p),
         pin_cfg[p][gcs_pkg::MODE_LSB +: 4], general_output_value,
         signal_detect, cdr_locked, por_status, clks);
      assign gpio_oe[p]         = pin_cfg[p][gcs_pkg::OE_BIT];
      assign input_buffer_on[p] = pin_cfg[p][gcs_pkg::IBUF_BIT];
      assign pull_up_on[p]      =
         (pin_cfg[p][gcs_pkg::PULL_LSB +: 2] == gcs_pkg::PULL_UP);
      assign pull_down_on[p]    =
         (pin_cfg[p][gcs_pkg::PULL_LSB +: 2] == gcs_pkg::PULL_DOWN);
   end

   assign gp_in_seen = gpio_in & input_buffer_on;

   // ****************************************
   // read back
   // ****************************************
   always_comb begin
      case (regs.addr)
         gcs_pkg::OFF_RESET:    read_value = {7'h00, soft_reset_request};
         gcs_pkg::OFF_PIN_CFG0: read_value = pin_cfg[0];
         gcs_pkg::OFF_PIN_CFG1: read_value = pin_cfg[1];
         gcs_pkg::OFF_PIN_CFG2: read_value = pin_cfg[2];
         gcs_pkg::OFF_GP_IN:    read_value = {5'h00, gp_in_seen};
         gcs_pkg::OFF_GP_OUT:   read_value = {5'h00, general_output_value};
         default:               read_value = 8'h00;
      endcase
   end

   assign regs.rdata = read_value;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   pin0_register_a: assert property (
      (pin_cfg[0][7:4] == gcs_pkg::SRC0_GPO)
         |-> (gpio_out[0] == general_output_value[0])
   ) else $error("pin 0 does not follow output bit");

   pin0_detect_a: assert property (
      (pin_cfg[0][7:4] == gcs_pkg::SRC0_SD0)
         |-> (gpio_out[0] == signal_detect[0])
   ) else $error("pin 0 does not follow signal detect");

   pin1_lock_a: assert property (
      (pin_cfg[1][7:4] == gcs_pkg::SRC1_LOCK) |-> (gpio_out[1] == cdr_locked)
   ) else $error("pin 1 does not follow lock");

   pin1_por_a: assert property (
      (pin_cfg[1][7:4] == gcs_pkg::SRC1_POR) |-> (gpio_out[1] == por_status)
   ) else $error("pin 1 does not follow power-on flag");

   pin2_clock_a: assert property (
      (pin_cfg[2][7:4] == gcs_pkg::SRC2_TX_CLK) |-> (gpio_out[2] == lvds_tx_clk)
   ) else $error("pin 2 does not follow transmit clock");

   pull_exclusive_a: assert property (
      !(|(pull_up_on & pull_down_on))
   ) else $error("pull up and pull down both on");

   soft_defaults_a: assert property (
      soft_reset_request |=> (input_buffer_on == 3'h0
         && gpio_oe == gcs_pkg::GPIO_OE_RESET && pull_down_on == 3'h7)
   ) else $error("soft reset did not restore pin defaults");

   oe_write_a: assert property (
      (wr_cfg[0] && !soft_reset_request && !regs.wdata[0]) |=> !gpio_oe[0]
   ) else $error("output driver not turned off by write");

   reset_sequence_a: assert property (
      (wr_reset && regs.wdata[0]) |=> soft_reset_request
         ##1 (!soft_reset_request && pin_cfg[1] == gcs_pkg::CFG_RESET
              && general_output_value == gcs_pkg::GP_OUT_RESET)
   ) else $error("soft reset sequence wrong");

   reset_readback_a: assert property (
      soft_reset_request |=> !soft_reset_request
   ) else $error("soft reset bit did not clear");

   cfg_write_c:  cover property (wr_cfg[2] ##1 pin_cfg[2][7:4] == 4'h3);
   soft_reset_c: cover property (soft_reset_request);
   lock_out_c:   cover property (pin_cfg[1][7:4] == 4'h3 && gpio_out[1]);

endmodule : gcs_gpio_config
`default_nettype wire

//--- hdl/gcs_pkg.sv
`default_nettype none
package gcs_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] OFF_RESET     = 8'h01;
   localparam logic [7:0] OFF_PIN_CFG0  = 8'h02;
   localparam logic [7:0] OFF_PIN_CFG1  = 8'h03;
   localparam logic [7:0] OFF_PIN_CFG2  = 8'h04;
   localparam logic [7:0] OFF_GP_IN     = 8'h05;
   localparam logic [7:0] OFF_GP_OUT    = 8'h06;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int         MODE_LSB      = 4;
   localparam int         PULL_LSB      = 2;
   localparam int         IBUF_BIT      = 1;
   localparam int         OE_BIT        = 0;
   localparam int         SOFT_RST_BIT  = 0;
   localparam logic [7:0] CFG_RESET     = 8'h05;
   localparam logic [2:0] GP_OUT_RESET  = 3'h0;
   localparam logic [2:0] GPIO_OE_RESET = 3'h7;

   // ****************************************
   // pull and source codes
   // ****************************************
   localparam logic [1:0] PULL_NONE     = 2'h0;
   localparam logic [1:0] PULL_DOWN     = 2'h1;
   localparam logic [1:0] PULL_UP       = 2'h2;
   localparam logic [3:0] SRC0_GPO      = 4'h0;
   localparam logic [3:0] SRC0_SD0      = 4'h1;
   localparam logic [3:0] SRC1_POR      = 4'h0;
   localparam logic [3:0] SRC1_GPO      = 4'h1;
   localparam logic [3:0] SRC1_SD1      = 4'h2;
   localparam logic [3:0] SRC1_LOCK     = 4'h3;
   localparam logic [3:0] SRC2_GPO      = 4'h0;
   localparam logic [3:0] SRC2_AON_CLK  = 4'h1;
   localparam logic [3:0] SRC2_TX_CLK   = 4'h2;
   localparam logic [3:0] SRC2_REC_CLK  = 4'h3;

   // ****************************************
   // serial management bus
   // ****************************************
   localparam logic [6:0] DEV_ADDR      = 7'h2c;
   localparam logic [3:0] BYTE_BITS     = 4'h8;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_ADDR      = 4'h1,
      ST_ADDR_ACK  = 4'h2,
      ST_PTR       = 4'h3,
      ST_PTR_ACK   = 4'h4,
      ST_WDATA     = 4'h5,
      ST_WDATA_ACK = 4'h6,
      ST_RDATA     = 4'h7,
      ST_RDATA_ACK = 4'h8,
      ST_RLOAD     = 4'h9
   } gcs_bus_state_t;

endpackage : gcs_pkg
`default_nettype wire

//--- hdl/gcs_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gcs_reg_if;
   logic       wr_en;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport engine (output wr_en, addr, wdata, input rdata);
   modport regs   (input wr_en, addr, wdata, output rdata);
endinterface : gcs_reg_if
`default_nettype wire

//--- hdl/gcs_serial_slave.sv
`timescale 1ns/1ps
`default_nettype none
module gcs_serial_slave (
   // clock and reset
   input  wire logic  ref_clk,
   input  wire logic  arst_n,
   // management bus pins
   input  wire logic  scl_in,
   input  wire logic  sda_in,
   output logic       sda_out,
   output logic       sda_oe,
   input  wire logic  bus_select,
   // register access
   gcs_reg_if.engine  regs
);

   // ****************************************
   // line events
   // ****************************************
   logic                    scl_q;
   logic                    sda_q;
   gcs_pkg::gcs_bus_state_t state;
   logic [3:0]              bit_cnt;
   logic [7:0]              shreg;
   logic [7:0]              ptr;
   logic                    rw;
   logic                    sda_low;
   logic                    wr_pulse;
   wire                     scl_rise;
   wire                     scl_fall;
   wire                     start_seen;
   wire                     stop_seen;
   wire                     byte_done;
   wire                     addr_hit;

   assign scl_rise   = scl_in & ~scl_q;
   assign scl_fall   = ~scl_in & scl_q;
   assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;
   assign byte_done  = (bit_cnt == gcs_pkg::BYTE_BITS);
   assign addr_hit   = (shreg[7:1] == gcs_pkg::DEV_ADDR);

   assign sda_out     = 1'b0;
   assign sda_oe      = sda_low;
   assign regs.wr_en  = wr_pulse;
   assign regs.addr   = ptr;
   assign regs.wdata  = shreg;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // ****************************************
   // byte engine
   // ****************************************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state    <= gcs_pkg::ST_IDLE;
         bit_cnt  <= 4'h0;
         shreg    <= 8'h00;
         ptr      <= 8'h00;
         rw       <= 1'b0;
         sda_low  <= 1'b0;
         wr_pulse <= 1'b0;
      end else begin
         wr_pulse <= 1'b0;
         if (!bus_select || stop_seen) begin
            state   <= gcs_pkg::ST_IDLE;
            sda_low <= 1'b0;
         end else if (start_seen) begin
            state   <= gcs_pkg::ST_ADDR;
            bit_cnt <= 4'h0;
            sda_low <= 1'b0;
         end else if (scl_rise) begin
            case (state)
               gcs_pkg::ST_ADDR, gcs_pkg::ST_PTR, gcs_pkg::ST_WDATA: begin
                  shreg   <= {shreg[6:0], sda_in};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               gcs_pkg::ST_RDATA: begin
                  shreg   <= {shreg[6:0], 1'b0};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               gcs_pkg::ST_RDATA_ACK: begin
                  if (sda_in) begin
                     state <= gcs_pkg::ST_IDLE;
                  end else begin
                     ptr   <= ptr + 8'h01;
                     state <= gcs_pkg::ST_RLOAD;
                  end
               end
               default: ;
            endcase
         end else if (scl_fall) begin
            case (state)
               gcs_pkg::ST_ADDR: begin
                  if (byte_done && addr_hit) begin
                     sda_low <= 1'b1;
                     rw      <= shreg[0];
                     state   <= gcs_pkg::ST_ADDR_ACK;
                  end else if (byte_done) begin
                     state <= gcs_pkg::ST_IDLE;
                  end
               end
               gcs_pkg::ST_ADDR_ACK: begin
                  bit_cnt <= 4'h0;
                  if (rw) begin
                     shreg   <= regs.rdata;
                     sda_low <= ~regs.rdata[7];
                     state   <= gcs_pkg::ST_RDATA;
                  end else begin
                     sda_low <= 1'b0;
                     state   <= gcs_pkg::ST_PTR;
                  end
               end
               gcs_pkg::ST_RLOAD: begin
                  bit_cnt <= 4'h0;
                  shreg   <= regs.rdata;
                  sda_low <= ~regs.rdata[7];
                  state   <= gcs_pkg::ST_RDATA;
               end
               gcs_pkg::ST_PTR: begin
                  if (byte_done) begin
                     ptr     <= shreg;
                     sda_low <= 1'b1;
                     state   <= gcs_pkg::ST_PTR_ACK;
                  end
               end
               gcs_pkg::ST_PTR_ACK: begin
                  sda_low <= 1'b0;
                  bit_cnt <= 4'h0;
                  state   <= gcs_pkg::ST_WDATA;
               end
               gcs_pkg::ST_WDATA: begin
                  if (byte_done) begin
                     wr_pulse <= 1'b1;
                     sda_low  <= 1'b1;
                     state    <= gcs_pkg::ST_WDATA_ACK;
                  end
               end
               gcs_pkg::ST_WDATA_ACK: begin
                  sda_low <= 1'b0;
                  bit_cnt <= 4'h0;
                  ptr     <= ptr + 8'h01;
                  state   <= gcs_pkg::ST_WDATA;
               end
               gcs_pkg::ST_RDATA: begin
                  if (byte_done) begin
                     sda_low <= 1'b0;
                     state   <= gcs_pkg::ST_RDATA_ACK;
                  end else begin
                     sda_low <= ~shreg[7];
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   addr_ack_drive_a: assert property (
      (bus_select && !start_seen && !stop_seen && scl_fall && byte_done
       && addr_hit && state == gcs_pkg::ST_ADDR) |=> sda_oe
   ) else $error("address match not acknowledged");

   deselect_idle_a: assert property (
      !bus_select |=> (state == gcs_pkg::ST_IDLE && !sda_oe)
   ) else $error("bus not released on deselect");

   write_cover_c: cover property (wr_pulse);
   read_cover_c:  cover property (state == gcs_pkg::ST_RDATA_ACK);

endmodule : gcs_serial_slave
`default_nettype wire

//--- testbench/gcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gcs_host_model (
   // clock
   input  wire logic ref_clk,
   // bus lines
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda_line
);
   // ****************************************
   // bus cycles, changed on falling edges
   // ****************************************
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : wt
   task automatic start_cond();
      sda_low = 1'b0;
      wt(3);
      scl = 1'b1;
      wt(4);
      sda_low = 1'b1;
      wt(4);
      scl = 1'b0;
      wt(1);
   endtask : start_cond
   task automatic stop_cond();
      sda_low = 1'b1;
      wt(3);
      scl = 1'b1;
      wt(4);
      sda_low = 1'b0;
      wt(4);
   endtask : stop_cond
   // data set while scl low, sampled while high
   task automatic bit_cyc(input logic low, output logic seen);
      sda_low = low;
      wt(5);
      scl = 1'b1;
      wt(2);
      seen = sda_line;
      wt(2);
      scl = 1'b0;
      wt(1);
   endtask : bit_cyc
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(~b[i], s);
      end
      bit_cyc(1'b0, s);
      ack = ~s;
   endtask : send_byte
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(1'b0, s);
         b[i] = s;
      end
      bit_cyc(~last, s);
   endtask : recv_byte
endmodule : gcs_host_model
`default_nettype wire

//--- testbench/test_gcs_gpio_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_gcs_gpio_config;
   localparam logic [7:0] dev_w = {gcs_pkg::DEV_ADDR, 1'b0};
   logic       ref_clk    = 1'b0;
   logic       arst_n     = 1'b0;
   logic       bus_select = 1'b1;
   logic [6:0] src        = 7'h08;
   logic [2:0] gpio_in    = 3'h6;
   logic       scl, sda_low, sda_out, sda_oe, sda_w;
   logic [2:0] gpio_out, gpio_oe, ibuf_on, pu_on, pd_on;
   logic [7:0] rd;
   logic [9:0] v;
   int         miscompares = 0;
   int         n_tests     = 0;
   int         cycles      = 0;
   logic [9:0] tbl [10] = '{10'h007, 10'h010, 10'h103, 10'h118, 10'h121,
                            10'h132, 10'h209, 10'h214, 10'h225, 10'h236};
   always #2.5 ref_clk = ~ref_clk;
   assign sda_w = ~sda_low & (sda_oe ? sda_out : 1'b1);
   gcs_host_model gcs_host_model_i (.ref_clk(ref_clk), .scl(scl),
      .sda_low(sda_low), .sda_line(sda_w));
   gcs_gpio_config #(.PINS(3)) gcs_gpio_config_i (
      .ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe), .bus_select(bus_select),
      .signal_detect(src[1:0]), .cdr_locked(src[2]), .por_status(src[3]),
      .always_on_clk(src[4]), .lvds_tx_clk(src[5]),
      .recovered_clk(src[6]), .gpio_in(gpio_in), .gpio_out(gpio_out),
      .gpio_oe(gpio_oe), .input_buffer_on(ibuf_on), .pull_up_on(pu_on),
      .pull_down_on(pd_on));
   // ****************************************
   // compare, verdict, bus access
   // ****************************************
   task automatic check(input string what, input logic [11:0] seen,
                        input logic [11:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic test_done();
      if (miscompares == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   task automatic reg_write(input logic [7:0] dv, a, d, input logic ok);
      logic k;
      gcs_host_model_i.start_cond();
      gcs_host_model_i.send_byte(dv, k);
      check("addr ack", {11'h0, k}, {11'h0, ok});
      gcs_host_model_i.send_byte(a, k);
      gcs_host_model_i.send_byte(d, k);
      check("data ack", {11'h0, k}, {11'h0, ok});
      gcs_host_model_i.stop_cond();
   endtask : reg_write
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      logic k;
      gcs_host_model_i.start_cond();
      gcs_host_model_i.send_byte(dev_w, k);
      gcs_host_model_i.send_byte(a, k);
      gcs_host_model_i.start_cond();
      gcs_host_model_i.send_byte(dev_w | 8'h01, k);
      gcs_host_model_i.recv_byte(1'b1, d);
      gcs_host_model_i.stop_cond();
   endtask : reg_read
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         test_done();
      end
   end
   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (12) @(negedge ref_clk);
      check("rst pins", {gpio_oe, ibuf_on, pu_on, pd_on}, 12'he07);
      check("rst out", {9'h0, gpio_out}, 12'h002);
      arst_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      for (logic [7:0] a = 8'h02; a < 8'h05; a++) begin
         reg_read(a, rd);
         check("cfg rst", {4'h0, rd}, 12'h005);
      end
      reg_read(8'h01, rd);
      check("srst rst", {4'h0, rd}, 12'h000);
      reg_write(dev_w, 8'h06, 8'h05, 1'b1);
      for (int k = 0; k < 10; k++) begin
         reg_write(dev_w, 8'h02 + tbl[k][9:8], {tbl[k][7:4], 4'h5}, 1'b1);
         for (int inv = 0; inv < 2; inv++) begin
            src = 7'h01 << tbl[k][3:0];
            src = (inv != 0) ? ~src : src;
            v = {3'h5, src};
            @(negedge ref_clk);
            check("mux", {11'h0, gpio_out[tbl[k][9:8]]},
                  {11'h0, v[tbl[k][3:0]]});
         end
      end
      src = 7'h08;
      for (int n = 0; n < 16; n++) begin
         reg_write(dev_w, 8'h02, 8'(n), 1'b1);
         reg_read(8'h02, rd);
         check("cfg rb", {4'h0, rd}, 12'(n));
         check("cfg pins", {8'h0, gpio_oe[0], ibuf_on[0], pu_on[0], pd_on[0]},
               12'({n[0], n[1], n[3:2] == 2'b10, n[3:2] == 2'b01}));
      end
      reg_write(dev_w, 8'h02, 8'h2f, 1'b1);
      src = 7'h7f;
      @(negedge ref_clk);
      check("reserved", {11'h0, gpio_out[0]}, 12'h000);
      src = 7'h08;
      reg_write(dev_w, 8'h03, 8'h16, 1'b1);
      reg_read(8'h05, rd);
      check("gp in", {4'h0, rd}, 12'h002);
      reg_write(dev_w, 8'h01, 8'h01, 1'b1);
      repeat (3) @(negedge ref_clk);
      check("srst pins", {gpio_oe, ibuf_on, pu_on, pd_on}, 12'he07);
      check("srst out", {9'h0, gpio_out}, 12'h002);
      reg_read(8'h01, rd);
      check("srst bit", {4'h0, rd}, 12'h000);
      reg_read(8'h06, rd);
      check("gp out", {4'h0, rd}, 12'h000);
      bus_select = 1'b0;
      reg_write(dev_w, 8'h02, 8'h00, 1'b0);
      bus_select = 1'b1;
      reg_write(8'h5a, 8'h02, 8'h00, 1'b0);
      reg_read(8'h02, rd);
      check("no write", {4'h0, rd}, 12'h005);
      test_done();
   end
endmodule : test_gcs_gpio_config
`default_nettype wire
